//--- smc_map.svh
// Purpose: Offsets, fields, codes and cycle counts of the sleep controller
// Assumes: Included by bare name, definitions only
// Notes: Byte addresses on the AXI4-Lite register bus
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH

// Register byte addresses
`define SMC_A_CTRL 8'h00
`define SMC_A_CFG 8'h04
`define SMC_A_STAT 8'h08

// Sleep control fields: enable in bit 0, mode select in bits 3:1
`define SMC_CTRL_SE 0
`define SMC_CTRL_SM_LO 1
`define SMC_CTRL_SM_HI 3
`define SMC_CTRL_RST 4'h0

// Configuration fields
`define SMC_CFG_ADC_EN 0
`define SMC_CFG_LCD_EN 1
`define SMC_CFG_LCD_ASY 2
`define SMC_CFG_TMR_EN 3
`define SMC_CFG_TMR_ASY 4
`define SMC_CFG_XTAL 5
`define SMC_CFG_EXTERNAL_INT_LINE_ZERO_LVL 6
`define SMC_CFG_EXTERNAL_INT_LINE_ZERO_EN 7
`define SMC_CFG_FUSE_LO 8
`define SMC_CFG_FUSE_HI 9
`define SMC_CFG_PC_EN 10
`define SMC_CFG_RST 11'h000

// Mode select codes
`define SMC_SM_IDLE 3'h0
`define SMC_SM_ADCNR 3'h1
`define SMC_SM_PDOWN 3'h2
`define SMC_SM_PSAVE 3'h3
`define SMC_SM_STBY 3'h6

// Cycle counts: halt after start-up, standby wake, fuse start-up table
`define SMC_HALT_CYC 16'h0004
`define SMC_STBY_CYC 16'h0006
`define SMC_SU_F0 16'h0040
`define SMC_SU_F1 16'h0400
`define SMC_SU_F2 16'h1000

// AXI responses
`define SMC_RESP_OKAY 2'h0
`define SMC_RESP_SLVERR 2'h2

`endif

//--- smc_pkg.sv
// Purpose: Types of the sleep controller
// Assumes: Nothing beyond the language
// Notes: Constants live in smc_map.svh
package smc_pkg;
  typedef enum logic [1:0] {S_RUN, S_SLEEP, S_START, S_HALT} smc_state_t;
  typedef enum logic [2:0] {
    M_IDLE, M_ADCNR, M_PDOWN, M_PSAVE, M_STBY
  } smc_mode_t;
endpackage : smc_pkg

//--- smc_top.sv
// Purpose: Sleep-mode controller with AXI4-Lite registers
// Assumes: sleep_instr, irq levels and masks come from logic on aclk
// Notes: Wake pins and reset requests are synchronised here
// Summary of operation
// - Sleep needs enable bit plus sleep instruction
// - Interrupt wake: halt four cycles past start-up
// - Memories untouched across sleep and wake
// - Reset while asleep resumes at reset vector
// - Mode 000 idle: only core clocks stop
// - Idle wakes on any enabled interrupt
// - Idle or noise mode starts ADC conversion
// - Mode 001: converter, async clocks, oscillator run
// - Noise mode wakes on its listed sources
// - Mode 010 power-down: all generated clocks stop
// - Power-down wakes on resets, serial, level, pin
// - Deep modes: line zero wakes on level only
// - Power-down wake waits fuse-selected start-up
// - Mode 011 power-save keeps timer and LCD
// - Power-save also wakes on timer or LCD
// - Power-save stops unused oscillators
// - Power-save sync clock reaches LCD, timer only
// - Mode 110 with crystal: standby, six cycles
// - Timer oscillator on only for async users
`include "smc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module smc_top import smc_pkg::*; #(
  parameter int SU_LONG = 16384
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic sleep_instr,
  input wire logic global_ie,
  input wire logic [1:0] async_timer_irq_mask,
  input wire logic adc_done_irq,
  input wire logic spm_ready_irq,
  input wire logic other_io_irq,
  input wire logic external_int_line_zero_n,
  input wire logic pin_change,
  input wire logic usi_start,
  input wire logic lcd_irq,
  input wire logic tmr_ovf,
  input wire logic tmr_cmp,
  input wire logic ext_rst_req,
  input wire logic wdt_rst_req,
  input wire logic bod_rst_req,
  output logic core_clock_en,
  output logic program_memory_clock_en,
  output logic peripheral_clock_en,
  output logic converter_clock_en,
  output logic asynchronous_clock_en,
  output logic main_osc_en,
  output logic timer_osc_en,
  output logic lcd_tmr_sync_clk_en,
  output logic core_halt,
  output logic mem_hold,
  output logic adc_start,
  output logic resume_irq,
  output logic resume_reset,
  output logic sleep_skip
);

  smc_state_t state_ff, nxt_state;
  smc_mode_t mode_ff, ent_mode;
  logic [15:0] cnt_ff, nxt_cnt, dly;
  logic [3:0] ctrl_ff;
  logic [10:0] cfg_ff;
  logic [8:0] sync1_ff, sync2_ff;
  logic external_int_line_zero_d_ff, by_rst_ff;
  logic [7:0] clk_ff;
  logic aw_ok_ff, w_ok_ff, bvalid_ff, rvalid_ff;
  logic [7:0] waddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic halt_ff, hold_ff, adc_st_ff, res_irq_ff, res_rst_ff, skip_ff;
  logic ent_ok, go_sleep, skip, src, wake_any, rst_s, resume;
  logic async_use, sync_use, external_int_line_zero_lvl, external_int_line_zero_edge, tmr_w, wr_go;
  logic [2:0] sm;
  logic aresetn_q;

  assign sm = ctrl_ff[`SMC_CTRL_SM_HI:`SMC_CTRL_SM_LO];
  assign async_use = (cfg_ff[`SMC_CFG_LCD_EN] & cfg_ff[`SMC_CFG_LCD_ASY])
    | (cfg_ff[`SMC_CFG_TMR_EN] & cfg_ff[`SMC_CFG_TMR_ASY]);
  assign sync_use = (cfg_ff[`SMC_CFG_LCD_EN] & ~cfg_ff[`SMC_CFG_LCD_ASY])
    | (cfg_ff[`SMC_CFG_TMR_EN] & ~cfg_ff[`SMC_CFG_TMR_ASY]);

  // Two-stage synchroniser for every pin-side wake or reset source
  // Stages reset to each pin's idle level, so no false wake after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= 9'h001;
      sync2_ff <= 9'h001;
    end else begin
      sync1_ff <= {bod_rst_req, wdt_rst_req, ext_rst_req, tmr_cmp,
        tmr_ovf, lcd_irq, usi_start, pin_change,
        external_int_line_zero_n};
      sync2_ff <= sync1_ff;
    end
  end

  // Third stage only feeds the falling-edge detector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      external_int_line_zero_d_ff <= 1'b1;
    end else begin
      external_int_line_zero_d_ff <= sync2_ff[0];
    end
  end

  // Wake sources, already qualified by their own enables
  assign rst_s = |sync2_ff[8:6];
  assign external_int_line_zero_lvl = cfg_ff[`SMC_CFG_EXTERNAL_INT_LINE_ZERO_EN] & cfg_ff[`SMC_CFG_EXTERNAL_INT_LINE_ZERO_LVL]
    & ~sync2_ff[0];
  assign external_int_line_zero_edge = cfg_ff[`SMC_CFG_EXTERNAL_INT_LINE_ZERO_EN] & ~cfg_ff[`SMC_CFG_EXTERNAL_INT_LINE_ZERO_LVL]
    & external_int_line_zero_d_ff & ~sync2_ff[0];
  assign tmr_w = (sync2_ff[4] & async_timer_irq_mask[0])
    | (sync2_ff[5] & async_timer_irq_mask[1]);

  // Per-mode wake filter; edge wake on line zero is idle-only
  always_comb begin
    src = 1'b0;
    case (mode_ff)
      M_IDLE: src = external_int_line_zero_lvl | external_int_line_zero_edge
        | (sync2_ff[1] & cfg_ff[`SMC_CFG_PC_EN])
        | sync2_ff[2] | sync2_ff[3] | tmr_w | spm_ready_irq
        | adc_done_irq | other_io_irq;
      M_ADCNR: src = external_int_line_zero_lvl | (sync2_ff[1] & cfg_ff[`SMC_CFG_PC_EN])
        | sync2_ff[2] | sync2_ff[3] | tmr_w | spm_ready_irq
        | adc_done_irq;
      M_PDOWN, M_STBY: src = external_int_line_zero_lvl
        | (sync2_ff[1] & cfg_ff[`SMC_CFG_PC_EN])
        | sync2_ff[2];
      M_PSAVE: src = external_int_line_zero_lvl | (sync2_ff[1] & cfg_ff[`SMC_CFG_PC_EN])
        | sync2_ff[2] | tmr_w | sync2_ff[3];
      default: src = 1'b0;
    endcase
  end
  // Interrupts wake only with the global enable; resets always wake
  assign wake_any = rst_s | (global_ie & src);

  // Mode decode at the sleep instruction; reserved codes do nothing
  always_comb begin
    ent_ok = 1'b1;
    ent_mode = M_IDLE;
    case (sm)
      `SMC_SM_IDLE: ent_mode = M_IDLE;
      `SMC_SM_ADCNR: ent_mode = M_ADCNR;
      `SMC_SM_PDOWN: ent_mode = M_PDOWN;
      `SMC_SM_PSAVE: ent_mode = M_PSAVE;
      // Standby needs a crystal; otherwise power-down is the safe fallback
      `SMC_SM_STBY: ent_mode = cfg_ff[`SMC_CFG_XTAL] ? M_STBY : M_PDOWN;
      default: ent_ok = 1'b0;
    endcase
  end
  assign go_sleep = (state_ff == S_RUN) & sleep_instr
    & ctrl_ff[`SMC_CTRL_SE] & ent_ok;
  assign skip = (state_ff == S_RUN) & sleep_instr & ~go_sleep;

  // Start-up delay: none in idle and noise, six cycles in standby, fuse table otherwise
  always_comb begin
    case (mode_ff)
      M_IDLE, M_ADCNR: dly = 16'h0000;
      M_STBY: dly = `SMC_STBY_CYC;
      default: begin
        case (cfg_ff[`SMC_CFG_FUSE_HI:`SMC_CFG_FUSE_LO])
          2'h0: dly = `SMC_SU_F0;
          2'h1: dly = `SMC_SU_F1;
          2'h2: dly = `SMC_SU_F2;
          default: dly = 16'(SU_LONG);
        endcase
      end
    endcase
  end

  // Sleep sequence: sleep, clock start-up, four-cycle halt, run
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      S_RUN: if (go_sleep) begin
        nxt_state = S_SLEEP;
      end
      S_SLEEP: if (wake_any) begin
        if (dly == 16'h0000) begin
          nxt_state = S_HALT;
          nxt_cnt = `SMC_HALT_CYC - 16'h0001;
        end else begin
          nxt_state = S_START;
          nxt_cnt = dly - 16'h0001;
        end
      end
      S_START: if (cnt_ff == 16'h0000) begin
        nxt_state = S_HALT;
        nxt_cnt = `SMC_HALT_CYC - 16'h0001;
      end else begin
        nxt_cnt = cnt_ff - 16'h0001;
      end
      S_HALT: if (cnt_ff == 16'h0000) begin
        nxt_state = S_RUN;
      end else begin
        nxt_cnt = cnt_ff - 16'h0001;
      end
      default: nxt_state = S_RUN;
    endcase
  end
  assign resume = (state_ff == S_HALT) & (cnt_ff == 16'h0000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= S_RUN;
      cnt_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // Mode is frozen at entry so register writes cannot move a sleeper
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= M_IDLE;
    end else if (go_sleep) begin
      mode_ff <= ent_mode;
    end
  end

  // A reset seen anywhere in the wake path redirects to the vector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      by_rst_ff <= 1'b0;
    end else if (state_ff == S_RUN) begin
      by_rst_ff <= 1'b0;
    end else if (rst_s) begin
      by_rst_ff <= 1'b1;
    end
  end

  // Clock plan {lt_sync, tosc, mosc, asy, adc, io, flash, core}
  function automatic logic [7:0] clk_plan(smc_state_t st, smc_mode_t md,
                                          logic au, logic su);
    logic r;
    r = (st == S_RUN);
    if (st != S_SLEEP) begin
      return {1'b1, au, 4'hf, r, r};
    end
    case (md)
      M_IDLE: return {1'b1, au, 4'hf, 2'h0};
      M_ADCNR: return {1'b0, au, 3'h7, 3'h0};
      M_PSAVE: return {su, au, su, au, 4'h0};
      M_STBY: return 8'h20;
      default: return 8'h00;
    endcase
  endfunction : clk_plan

  // Outputs register the next state so they line up with state_ff
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_ff <= 8'hff;
      halt_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else begin
      clk_ff <= clk_plan(nxt_state, go_sleep ? ent_mode : mode_ff,
                         async_use, sync_use);
      halt_ff <= (nxt_state != S_RUN);
      hold_ff <= (nxt_state != S_RUN);
    end
  end

  // One-cycle event pulses towards core and ADC
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adc_st_ff <= 1'b0;
      res_irq_ff <= 1'b0;
      res_rst_ff <= 1'b0;
      skip_ff <= 1'b0;
    end else begin
      adc_st_ff <= go_sleep & cfg_ff[`SMC_CFG_ADC_EN]
        & (ent_mode == M_IDLE || ent_mode == M_ADCNR);
      res_irq_ff <= resume & ~(by_rst_ff | rst_s);
      res_rst_ff <= resume & (by_rst_ff | rst_s);
      skip_ff <= skip;
    end
  end

  // AXI write: address and data taken in either order, then answered
  assign wr_go = aw_ok_ff & w_ok_ff & ~bvalid_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `SMC_RESP_OKAY;
      waddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else begin
      if (awvalid && !aw_ok_ff) begin
        aw_ok_ff <= 1'b1;
        waddr_ff <= awaddr;
      end
      if (wvalid && !w_ok_ff) begin
        w_ok_ff <= 1'b1;
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= (waddr_ff == `SMC_A_CTRL || waddr_ff == `SMC_A_CFG)
          ? `SMC_RESP_OKAY : `SMC_RESP_SLVERR;
      end else if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
      end
    end
  end

  // Register stores with byte lanes; status is read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= `SMC_CTRL_RST;
      cfg_ff <= `SMC_CFG_RST;
    end else if (wr_go) begin
      if (waddr_ff == `SMC_A_CTRL && wstrb_ff[0]) begin
        ctrl_ff <= wdata_ff[3:0];
      end
      if (waddr_ff == `SMC_A_CFG) begin
        if (wstrb_ff[0]) begin
          cfg_ff[7:0] <= wdata_ff[7:0];
        end
        if (wstrb_ff[1]) begin
          cfg_ff[10:8] <= wdata_ff[10:8];
        end
      end
    end
  end

  // AXI read: one outstanding read, answer one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `SMC_RESP_OKAY;
    end else if (arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= `SMC_RESP_OKAY;
      case (araddr)
        `SMC_A_CTRL: rdata_ff <= {28'h0000000, ctrl_ff};
        `SMC_A_CFG: rdata_ff <= {21'h000000, cfg_ff};
        `SMC_A_STAT: rdata_ff <= {18'h00000, by_rst_ff, clk_ff,
                                  mode_ff, state_ff};
        default: begin
          rdata_ff <= 32'h00000000;
          rresp_ff <= `SMC_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign awready = ~aw_ok_ff & aresetn_q;
  assign wready = ~w_ok_ff & aresetn_q;
  assign arready = ~rvalid_ff & aresetn_q;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign {lcd_tmr_sync_clk_en, timer_osc_en, main_osc_en,
          asynchronous_clock_en, converter_clock_en, peripheral_clock_en,
          program_memory_clock_en, core_clock_en} = clk_ff;
  assign core_halt = halt_ff;
  assign mem_hold = hold_ff;
  assign adc_start = adc_st_ff;
  assign resume_irq = res_irq_ff;
  assign resume_reset = res_rst_ff;
  assign sleep_skip = skip_ff;

  // Ready flag held low through reset so no beat is taken early
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aresetn_q <= 1'b0;
    end else begin
      aresetn_q <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_halt_entry;
    state_ff == S_START ##1 state_ff == S_HALT;
  endsequence
  sequence s_stby_wake;
    state_ff == S_SLEEP && mode_ff == M_STBY && wake_any;
  endsequence

  a_sleep_entry: assert property (
    state_ff == S_RUN && sleep_instr && ctrl_ff[`SMC_CTRL_SE]
    && sm == `SMC_SM_PDOWN |=> state_ff == S_SLEEP && core_halt
    && !core_clock_en) else $error("sleep not entered");
  a_halt_four: assert property (
    s_halt_entry |-> core_halt[*4] ##1 (!core_halt && state_ff == S_RUN))
    else $error("halt not four cycles");
  a_mem_retain: assert property (
    state_ff != S_RUN |-> mem_hold && core_halt)
    else $error("memory hold dropped while halted");
  a_reset_vec: assert property (
    state_ff == S_HALT && cnt_ff == 16'h0000 && by_rst_ff
    |=> resume_reset && !resume_irq) else $error("reset wake resumed");
  a_idle_clocks: assert property (
    state_ff == S_SLEEP && mode_ff == M_IDLE |-> !core_clock_en
    && !program_memory_clock_en && peripheral_clock_en
    && converter_clock_en && asynchronous_clock_en)
    else $error("idle clocks wrong");
  a_adc_start: assert property (
    state_ff == S_SLEEP && $past(state_ff) == S_RUN
    && mode_ff == M_ADCNR && cfg_ff[`SMC_CFG_ADC_EN] |-> adc_start)
    else $error("no conversion on entry");
  a_pd_clocks: assert property (
    state_ff == S_SLEEP && mode_ff == M_PDOWN |-> clk_ff == 8'h00)
    else $error("clock alive in power-down");
  a_pd_only: assert property (
    state_ff == S_SLEEP && mode_ff == M_PDOWN && !rst_s && !external_int_line_zero_lvl
    && !sync2_ff[1] && !sync2_ff[2] |=> state_ff == S_SLEEP)
    else $error("power-down woke on bad source");
  a_ps_route: assert property (
    state_ff == S_SLEEP && mode_ff == M_PSAVE |-> !peripheral_clock_en
    && lcd_tmr_sync_clk_en == sync_use && timer_osc_en == async_use)
    else $error("power-save clock routing wrong");
  a_stby_six: assert property (
    s_stby_wake |-> ##7 state_ff == S_HALT)
    else $error("standby wake not six cycles");
  a_skip_noop: assert property (
    state_ff == S_RUN && sleep_instr && !ctrl_ff[`SMC_CTRL_SE]
    |=> state_ff == S_RUN && sleep_skip) else $error("skip failed");

endmodule : smc_top

`default_nettype wire

//--- smc_core_model.sv
// Purpose: Core and line-zero source beside the sleep controller
// Assumes: Driven by the bench on aclk rising edges
// Notes: Line zero idles high as on a pulled-up pin
`timescale 1ns/1ps
`default_nettype none

module smc_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic issue,
  input wire logic hold_lvl,
  input wire logic blip,
  input wire logic core_halt,
  output logic sleep_instr,
  output logic external_int_line_zero_n
);
  logic sleep_ff;
  logic low_ff;
  // Sleep is a single-cycle pulse, only while the core runs
  always_ff @(posedge aclk) begin
    if (!aresetn) sleep_ff <= 1'b0;
    else sleep_ff <= issue && !core_halt;
  end
  // Hold the low level until the core runs, so the wake is never lost
  always_ff @(posedge aclk) begin
    if (!aresetn) low_ff <= 1'b0;
    else if (hold_lvl) low_ff <= 1'b1;
    else if (!core_halt) low_ff <= 1'b0;
  end
  assign sleep_instr = sleep_ff;
  // A blip gives a bare falling edge of one cycle
  assign external_int_line_zero_n = !(low_ff || blip);
endmodule : smc_core_model
`default_nettype wire

//--- tb_sleep_mode_controller.sv
// Purpose: Self-checking bench of the sleep controller
// Assumes: Short start-up parameter, no random stimulus
// Notes: Wake latencies checked against small windows
`include "smc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_sleep_mode_controller;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, tmask;
  logic sleep_instr, lz_n, issue, hold_lvl, blip;
  logic adc_irq, spm_irq, io_irq, pin_chg, universal_serial_unit, lcd, ovf, cmp;
  logic ext_rst, wdt_rst, bod_rst, gie;
  logic c_core, c_flash, c_io, c_adc, c_asy, mosc, tosc, lt_sync;
  logic core_halt, mem_hold, adc_start, res_irq, res_rst, skip;
  logic [6:0] clk_v;
  int err_count, checks_done, cyc, adc_cnt, skip_cnt;
  logic [31:0] d;
  logic [1:0] r;

  smc_top #(.SU_LONG(8)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .sleep_instr(sleep_instr), .global_ie(gie),
    .async_timer_irq_mask(tmask), .adc_done_irq(adc_irq),
    .spm_ready_irq(spm_irq), .other_io_irq(io_irq),
    .external_int_line_zero_n(lz_n), .pin_change(pin_chg),
    .usi_start(universal_serial_unit), .lcd_irq(lcd), .tmr_ovf(ovf), .tmr_cmp(cmp),
    .ext_rst_req(ext_rst), .wdt_rst_req(wdt_rst), .bod_rst_req(bod_rst),
    .core_clock_en(c_core), .program_memory_clock_en(c_flash),
    .peripheral_clock_en(c_io), .converter_clock_en(c_adc),
    .asynchronous_clock_en(c_asy), .main_osc_en(mosc),
    .timer_osc_en(tosc), .lcd_tmr_sync_clk_en(lt_sync),
    .core_halt(core_halt), .mem_hold(mem_hold), .adc_start(adc_start),
    .resume_irq(res_irq), .resume_reset(res_rst), .sleep_skip(skip));

  smc_core_model u_core (.aclk(aclk), .aresetn(aresetn), .issue(issue),
    .hold_lvl(hold_lvl), .blip(blip), .core_halt(core_halt),
    .sleep_instr(sleep_instr), .external_int_line_zero_n(lz_n));

  assign clk_v = {c_core, c_flash, c_io, c_adc, c_asy, mosc, tosc};

  // 10 MHz clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  // Hang guard; the whole run needs well under 4000 cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  // Pulse counters, and memories held for exactly the halted time
  always @(negedge aclk) begin
    if (adc_start === 1'b1) adc_cnt++;
    if (skip === 1'b1) skip_cnt++;
    if (aresetn) chk(mem_hold, core_halt, "mem_hold");
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                        input logic [1:0] er);
    logic ah, wh, bh, done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1;
    wdata <= v; wstrb <= 4'hf; wvalid <= 1'b1; bready <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ah = awvalid && awready; wh = wvalid && wready;
      bh = bvalid && bready; r = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) begin
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    chk(r, er, "write response");
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    logic ah, rh, done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ah = arvalid && arready; rh = rvalid && rready;
      d = rdata; r = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
      if (rh) begin
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_rd

  task automatic pulse_issue();
    @(posedge aclk) issue <= 1'b1;
    @(posedge aclk) issue <= 1'b0;
    repeat (3) @(negedge aclk);
  endtask : pulse_issue

  // Configure, sleep, then judge clocks and the conversion start
  task automatic sleep_in(input logic [31:0] cfg, input logic [2:0] m,
                          input logic [6:0] ev, input int ea);
    int a0;
    axi_wr(`SMC_A_CFG, cfg, `SMC_RESP_OKAY);
    axi_wr(`SMC_A_CTRL, {28'h0, m, 1'b1}, `SMC_RESP_OKAY);
    a0 = adc_cnt;
    pulse_issue();
    chk(core_halt, 1'b1, "not asleep");
    chk(clk_v, ev, "clock enables");
    chk(adc_cnt - a0, ea, "conversion start");
  endtask : sleep_in

  // Count cycles until the core runs and judge the resume pulse
  task automatic wake_chk(input int lo, input int hi, input logic rst);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (core_halt !== 1'b0 && n < 5000);
    chk(n >= lo && n <= hi, 1'b1, "wake latency");
    chk({res_irq, res_rst}, {!rst, rst}, "resume kind");
    @(posedge aclk);
    {io_irq, adc_irq, universal_serial_unit, pin_chg, ovf, lcd, wdt_rst} <= 7'h00;
  endtask : wake_chk

  task automatic no_wake();
    repeat (20) @(negedge aclk);
    chk(core_halt, 1'b1, "woke on a refused source");
  endtask : no_wake

  task automatic t_regs();
    axi_rd(`SMC_A_CTRL);
    chk(d, 32'h0, "ctrl reset value");
    axi_rd(`SMC_A_CFG);
    chk(d, 32'h0, "cfg reset value");
    axi_wr(`SMC_A_STAT, 32'h1, `SMC_RESP_SLVERR);
    axi_rd(8'h0c);
    chk({d, r}, {32'h0, `SMC_RESP_SLVERR}, "unmapped read");
    $display("test regs done");
  endtask : t_regs

  // Enable clear, then a reserved code: both ignored
  task automatic t_skip();
    int s0;
    s0 = skip_cnt;
    axi_wr(`SMC_A_CTRL, 32'h0, `SMC_RESP_OKAY);
    pulse_issue();
    axi_wr(`SMC_A_CTRL, 32'h9, `SMC_RESP_OKAY);
    pulse_issue();
    chk(skip_cnt - s0, 2, "skip pulses");
    chk(core_halt, 1'b0, "halted on ignored sleep");
    $display("test skip done");
  endtask : t_skip

  task automatic t_light();
    sleep_in(32'h1, `SMC_SM_IDLE, 7'b0011110, 1);
    @(posedge aclk) io_irq <= 1'b1;
    wake_chk(4, 8, 1'b0);
    sleep_in(32'h19, `SMC_SM_ADCNR, 7'b0001111, 1);
    @(posedge aclk) io_irq <= 1'b1;
    no_wake();
    @(posedge aclk) adc_irq <= 1'b1;
    wake_chk(4, 8, 1'b0);
    $display("test idle and noise done");
  endtask : t_light

  task automatic t_deep();
    // Nothing runs, so power-down is the mode of choice
    sleep_in(32'h80, `SMC_SM_PDOWN, 7'b0000000, 0);
    @(posedge aclk) lcd <= 1'b1;
    blip <= 1'b1;
    @(posedge aclk) blip <= 1'b0;
    no_wake();
    @(posedge aclk) lcd <= 1'b0;
    universal_serial_unit <= 1'b1;
    wake_chk(68, 74, 1'b0);
    sleep_in(32'hc0, `SMC_SM_PDOWN, 7'b0000000, 0);
    @(posedge aclk) hold_lvl <= 1'b1;
    @(posedge aclk) hold_lvl <= 1'b0;
    wake_chk(67, 74, 1'b0);
    sleep_in(32'h500, `SMC_SM_PDOWN, 7'b0000000, 0);
    @(posedge aclk) pin_chg <= 1'b1;
    wake_chk(1028, 1034, 1'b0);
    sleep_in(32'h0, `SMC_SM_PDOWN, 7'b0000000, 0);
    @(posedge aclk) wdt_rst <= 1'b1;
    wake_chk(4, 80, 1'b1);
    $display("test power-down done");
  endtask : t_deep

  task automatic t_save();
    sleep_in(32'h18, `SMC_SM_PSAVE, 7'b0000101, 0);
    chk(lt_sync, 1'b0, "sync clock to timer");
    @(posedge aclk) tmask <= 2'b01;
    cmp <= 1'b1;
    no_wake();
    @(posedge aclk) cmp <= 1'b0;
    ovf <= 1'b1;
    wake_chk(68, 74, 1'b0);
    // Timer oscillator and its async clock stop with no async user
    sleep_in(32'h2, `SMC_SM_PSAVE, 7'b0000010, 0);
    chk(lt_sync, 1'b1, "sync clock to lcd");
    @(posedge aclk) lcd <= 1'b1;
    wake_chk(68, 74, 1'b0);
    sleep_in(32'h420, `SMC_SM_STBY, 7'b0000010, 0);
    @(posedge aclk) pin_chg <= 1'b1;
    wake_chk(10, 14, 1'b0);
    $display("test save and standby done");
  endtask : t_save

  // Main sequence: inputs at time zero, two-cycle reset
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, issue} = 7'h00;
    {hold_lvl, blip, adc_irq, spm_irq, io_irq, pin_chg, universal_serial_unit} = 7'h00;
    {lcd, ovf, cmp, ext_rst, wdt_rst, bod_rst} = 6'h00;
    {awaddr, araddr, wdata, wstrb, tmask} = 54'h0;
    gie = 1'b1;
    repeat (2) @(posedge aclk);
    chk(awready, 1'b0, "ready in reset");
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_skip();
    t_light();
    t_deep();
    t_save();
    give_verdict();
  end
endmodule : tb_sleep_mode_controller
`default_nettype wire
